/* verilog/adcsq_map.svh */
// Purpose: Register map, field positions and timing counts for the
//          converter sequencing block.
// Assumes: 100 MHz pclk, 32-bit APB data, byte addresses in paddr[7:0].
// Notes:   Definitions only.
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH

// ********************************
// Register offsets
// ********************************
`define ADCSQ_OFF_CTRL 8'h00
`define ADCSQ_OFF_DELAY 8'h04
`define ADCSQ_OFF_FLAGS 8'h08
`define ADCSQ_OFF_SINGLE 8'h0c
`define ADCSQ_OFF_REPEAT 8'h10
`define ADCSQ_OFF_RES_FIRST 8'h18
`define ADCSQ_OFF_RES_LAST 8'h34

// ********************************
// Control register fields
// ********************************
`define ADCSQ_CTRL_ACTIVATE 0
`define ADCSQ_CTRL_START_SINGLE 1
`define ADCSQ_CTRL_START_REPEAT 2
`define ADCSQ_CTRL_REPEAT_DONE 6
`define ADCSQ_CTRL_SINGLE_DONE 7

// ********************************
// Field layouts and reset values
// ********************************
`define ADCSQ_START_DELAY_LSB 0
`define ADCSQ_REPEAT_DELAY_LSB 16
`define ADCSQ_DELAY_W 16
`define ADCSQ_CH_N 8
`define ADCSQ_RES_W 10
`define ADCSQ_RESET_WORD 32'h0000_0000
`define ADCSQ_RESET_CH 8'h00
`define ADCSQ_RESET_DELAY 16'h0000
`define ADCSQ_RESET_RES 10'h000

// ********************************
// Timing
// ********************************
`define ADCSQ_CLK_PERIOD_NS 10
`define ADCSQ_DELAY_UNIT_US 40
`define ADCSQ_UNIT_CYCLES \
  ((`ADCSQ_DELAY_UNIT_US * 1000 + `ADCSQ_CLK_PERIOD_NS - 1) / \
   `ADCSQ_CLK_PERIOD_NS)
`define ADCSQ_TICK_W 12

`endif

/* verilog/adcsq_pkg.sv */
// Purpose: Types shared by the converter sequencing block.
// Assumes: Nothing beyond the map header.
// Notes:   Sequencer state codes are fixed binary.
`default_nettype none

package adcsq_pkg;

  typedef enum logic [2:0] {
    ADCSQ_IDLE = 3'b000,
    ADCSQ_START_WAIT = 3'b001,
    ADCSQ_PICK = 3'b010,
    ADCSQ_CONVERT = 3'b011,
    ADCSQ_GAP = 3'b100
  } adcsq_state_t;

  typedef logic [2:0] adcsq_ch_t;

endpackage : adcsq_pkg

`default_nettype wire

/* verilog/adcsq_result_mem.sv */
// Purpose: Eight-entry store of the latest channel readings.
// Assumes: One write and one read port, both on pclk.
// Notes:   Read data come out of a register, one cycle after the address.
`default_nettype none
`include "adcsq_map.svh"

module adcsq_result_mem
  import adcsq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire adcsq_ch_t wr_addr,
  input wire logic [`ADCSQ_RES_W-1:0] wr_data,
  input wire adcsq_ch_t rd_addr,
  output logic [`ADCSQ_RES_W-1:0] rd_data
);

  logic [`ADCSQ_RES_W-1:0] mem [`ADCSQ_CH_N];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `ADCSQ_CH_N; i++) begin
        mem[i] <= `ADCSQ_RESET_RES;
      end
      rd_data <= `ADCSQ_RESET_RES;
    end else if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule : adcsq_result_mem

`default_nettype wire

/* verilog/adcsq_top.sv */
// Purpose: APB register file and pass sequencer for an eight-channel
//          converter core.
// Assumes: Core takes conv_start with conv_channel, answers conv_done
//          with conv_data; all inputs synchronous to pclk.
// Notes:   Every APB transfer has one wait state.
//
// Chosen here: register access over APB.
`default_nettype none
`include "adcsq_map.svh"

module adcsq_top
  import adcsq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done,
  input wire logic [`ADCSQ_RES_W-1:0] conv_data,
  output logic conv_start,
  output adcsq_ch_t conv_channel,
  output logic converter_active
);

  // ********************************
  // Helpers
  // ********************************
  function automatic adcsq_ch_t lowest_set(input logic [7:0] mask);
    adcsq_ch_t idx;
    idx = 3'h0;
    for (int i = `ADCSQ_CH_N - 1; i >= 0; i--) begin
      if (mask[i]) begin
        idx = adcsq_ch_t'(i);
      end
    end
    return idx;
  endfunction : lowest_set

  function automatic logic [7:0] ch_bit(input adcsq_ch_t ch);
    return 8'h01 << ch;
  endfunction : ch_bit

  // ********************************
  // Registers and state
  // ********************************
  logic active;
  logic single_req;
  logic repeat_on;
  logic repeat_arm;
  logic single_done;
  logic repeat_done;
  logic [`ADCSQ_DELAY_W-1:0] start_delay;
  logic [`ADCSQ_DELAY_W-1:0] repeat_delay;
  logic [7:0] channel_done_flags;
  logic [7:0] single_sel;
  logic [7:0] repeat_sel;
  adcsq_state_t state;
  adcsq_state_t next_state;
  logic pass_repeat;
  logic [7:0] remaining;
  logic [`ADCSQ_DELAY_W-1:0] units_left;
  logic [`ADCSQ_TICK_W-1:0] tick;

  // ********************************
  // Bus decode
  // ********************************
  wire access = psel && penable;
  wire wr_take = access && pwrite && pready;
  wire in_res = (paddr >= `ADCSQ_OFF_RES_FIRST) &&
                (paddr <= `ADCSQ_OFF_RES_LAST) && (paddr[1:0] == 2'b00);
  wire [7:0] res_off = paddr - `ADCSQ_OFF_RES_FIRST;
  wire adcsq_ch_t res_idx = res_off[4:2];
  wire hit_ctrl = paddr == `ADCSQ_OFF_CTRL;
  wire hit_delay = paddr == `ADCSQ_OFF_DELAY;
  wire hit_flags = paddr == `ADCSQ_OFF_FLAGS;
  wire hit_single = paddr == `ADCSQ_OFF_SINGLE;
  wire hit_repeat = paddr == `ADCSQ_OFF_REPEAT;
  wire mapped = hit_ctrl || hit_delay || hit_flags || hit_single ||
                hit_repeat || in_res;
  wire wr_ctrl = wr_take && hit_ctrl;
  wire [`ADCSQ_RES_W-1:0] res_rd;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `ADCSQ_RESET_WORD;
    if (hit_ctrl) begin
      rd_mux[`ADCSQ_CTRL_ACTIVATE] = active;
      rd_mux[`ADCSQ_CTRL_START_SINGLE] = single_req;
      rd_mux[`ADCSQ_CTRL_START_REPEAT] = repeat_on;
      rd_mux[`ADCSQ_CTRL_REPEAT_DONE] = repeat_done;
      rd_mux[`ADCSQ_CTRL_SINGLE_DONE] = single_done;
    end else if (hit_delay) begin
      rd_mux = {repeat_delay, start_delay};
    end else if (hit_flags) begin
      rd_mux[7:0] = channel_done_flags;
    end else if (hit_single) begin
      rd_mux[7:0] = single_sel;
    end else if (hit_repeat) begin
      rd_mux[7:0] = repeat_sel;
    end else if (in_res) begin
      rd_mux[`ADCSQ_RES_W-1:0] = res_rd;
    end
  end

  // ********************************
  // APB answer
  // ********************************
  // Wait state gives the result store time to present a whole word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `ADCSQ_RESET_WORD;
    end else if (ce) begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      if (access && !pready) begin
        prdata <= pwrite ? `ADCSQ_RESET_WORD : rd_mux;
      end
    end
  end

  // ********************************
  // Sequencer decode
  // ********************************
  wire unit_end = tick == 12'(`ADCSQ_UNIT_CYCLES - 1);
  wire delay_over = units_left == `ADCSQ_RESET_DELAY;
  wire adcsq_ch_t pick_ch = lowest_set(remaining);
  wire launch_single = single_req && active;
  wire launch_repeat = repeat_arm && repeat_on && active;
  wire pass_end = state == ADCSQ_PICK && remaining == `ADCSQ_RESET_CH;
  wire got_result = state == ADCSQ_CONVERT && conv_done;
  wire begin_pass_single = state == ADCSQ_IDLE && launch_single;
  wire begin_pass_repeat = (state == ADCSQ_START_WAIT ||
                            state == ADCSQ_GAP) && delay_over &&
                           repeat_on && active;
  wire stop_wait = (state == ADCSQ_START_WAIT || state == ADCSQ_GAP) &&
                   !(repeat_on && active);

  always_comb begin
    next_state = state;
    unique case (state)
      ADCSQ_IDLE: begin
        if (launch_single) begin
          next_state = ADCSQ_PICK;
        end else if (launch_repeat) begin
          next_state = ADCSQ_START_WAIT;
        end
      end
      ADCSQ_START_WAIT, ADCSQ_GAP: begin
        if (stop_wait) begin
          next_state = ADCSQ_IDLE;
        end else if (begin_pass_repeat) begin
          next_state = ADCSQ_PICK;
        end
      end
      ADCSQ_PICK: begin
        if (pass_end) begin
          next_state = (pass_repeat && repeat_on && active) ?
                       ADCSQ_GAP : ADCSQ_IDLE;
        end else begin
          next_state = ADCSQ_CONVERT;
        end
      end
      ADCSQ_CONVERT: begin
        if (conv_done) begin
          next_state = ADCSQ_PICK;
        end
      end
      default: begin
        next_state = ADCSQ_IDLE;
      end
    endcase
  end

  // ********************************
  // Sequencer state
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ADCSQ_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining <= `ADCSQ_RESET_CH;
      pass_repeat <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= 3'h0;
    end else if (ce) begin
      conv_start <= state == ADCSQ_PICK && !pass_end;
      if (state == ADCSQ_PICK && !pass_end) begin
        conv_channel <= pick_ch;
      end
      if (begin_pass_single) begin
        remaining <= single_sel;
        pass_repeat <= 1'b0;
      end else if (begin_pass_repeat) begin
        remaining <= repeat_sel;
        pass_repeat <= 1'b1;
      end else if (got_result) begin
        remaining <= remaining & ~ch_bit(conv_channel);
      end
    end
  end

  // ********************************
  // Delay timer
  // ********************************
  // A 40 us unit is counted in ticks, so 0xffff units is about 2.6 s
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      units_left <= `ADCSQ_RESET_DELAY;
      tick <= 12'h000;
    end else if (ce) begin
      tick <= 12'h000;
      if (state == ADCSQ_IDLE && launch_repeat) begin
        units_left <= start_delay;
      end else if (pass_end) begin
        units_left <= repeat_delay;
      end else if ((state == ADCSQ_START_WAIT || state == ADCSQ_GAP) &&
                   !delay_over) begin
        if (unit_end) begin
          units_left <= units_left - 16'h0001;
        end else begin
          tick <= tick + 12'h001;
        end
      end
    end
  end

  // ********************************
  // Control and configuration
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      repeat_on <= 1'b0;
      start_delay <= `ADCSQ_RESET_DELAY;
      repeat_delay <= `ADCSQ_RESET_DELAY;
      single_sel <= `ADCSQ_RESET_CH;
      repeat_sel <= `ADCSQ_RESET_CH;
      converter_active <= 1'b0;
    end else if (ce) begin
      converter_active <= active || state != ADCSQ_IDLE;
      if (wr_ctrl) begin
        active <= pwdata[`ADCSQ_CTRL_ACTIVATE];
        repeat_on <= pwdata[`ADCSQ_CTRL_START_REPEAT];
      end
      if (wr_take && hit_delay) begin
        start_delay <= pwdata[`ADCSQ_START_DELAY_LSB +: `ADCSQ_DELAY_W];
        repeat_delay <= pwdata[`ADCSQ_REPEAT_DELAY_LSB +: `ADCSQ_DELAY_W];
      end
      if (wr_take && hit_single) begin
        single_sel <= pwdata[7:0];
      end
      if (wr_take && hit_repeat) begin
        repeat_sel <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_req <= 1'b0;
      repeat_arm <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl && pwdata[`ADCSQ_CTRL_START_SINGLE]) begin
        single_req <= 1'b1;
      end else if (begin_pass_single) begin
        single_req <= 1'b0;
      end
      // Arm on a rising repeat start so rewriting one does not restart
      if (wr_ctrl && pwdata[`ADCSQ_CTRL_START_REPEAT] && !repeat_on) begin
        repeat_arm <= 1'b1;
      end else if ((state == ADCSQ_IDLE && launch_repeat &&
                    !launch_single) || !repeat_on) begin
        repeat_arm <= 1'b0;
      end
    end
  end

  // ********************************
  // Completion flags
  // ********************************
  wire [7:0] flag_set = got_result ? ch_bit(conv_channel) : 8'h00;
  wire [7:0] flag_clr = (wr_take && hit_flags) ? pwdata[7:0] : 8'h00;
  wire clr_single = wr_ctrl && pwdata[`ADCSQ_CTRL_SINGLE_DONE];
  wire clr_repeat = wr_ctrl && pwdata[`ADCSQ_CTRL_REPEAT_DONE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_done_flags <= `ADCSQ_RESET_CH;
      single_done <= 1'b0;
      repeat_done <= 1'b0;
    end else if (ce) begin
      channel_done_flags <= (channel_done_flags & ~flag_clr) | flag_set;
      if (pass_end && !pass_repeat) begin
        single_done <= 1'b1;
      end else if (clr_single || begin_pass_single) begin
        single_done <= 1'b0;
      end
      if (pass_end && pass_repeat) begin
        repeat_done <= 1'b1;
      end else if (clr_repeat || begin_pass_repeat) begin
        repeat_done <= 1'b0;
      end
    end
  end

  // ********************************
  // Result store
  // ********************************
  // one entry per channel
  adcsq_result_mem u_results (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_en(got_result),
    .wr_addr(conv_channel),
    .wr_data(conv_data),
    .rd_addr(res_idx),
    .rd_data(res_rd)
  );

endmodule : adcsq_top

`default_nettype wire

/* dv/adcsq_chk.sv */
// Purpose: Port-level checks of the sequencing block.
// Assumes: ce held high by the bench.
// Notes:   Bound to adcsq_top below.
`default_nettype none
`include "adcsq_map.svh"
module adcsq_chk
  import adcsq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire adcsq_ch_t conv_channel,
  input wire logic converter_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_ok = psel && penable && pready && !pwrite && !pslverr;
  // ****************************************
  // Assertions
  // ****************************************
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_hole: assert property (pready && paddr == 8'h14 |-> pslverr)
    else $error("no error on unmapped offset");
  a_hole_zero: assert property (pready && !pwrite && paddr == 8'h14
    |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_res_upper: assert property (rd_ok && paddr >= 8'h18 && paddr <= 8'h34
    |-> prdata[31:10] == 22'h0)
    else $error("result upper bits not zero");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_done_gap: assert property (conv_done |=> !conv_start ##1 1)
    else $error("start too soon after done");
  a_chan_hold: assert property (!conv_start |-> $stable(conv_channel))
    else $error("channel moved without start");
  a_active_run: assert property (conv_start |=> converter_active)
    else $error("inactive during pass");
  c_done: cover property (conv_done);
  c_err: cover property (pready && pslverr);
  c_last: cover property (conv_start && conv_channel == 3'd7);
endmodule : adcsq_chk
bind adcsq_top adcsq_chk u_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
  .conv_start(conv_start), .conv_channel(conv_channel),
  .converter_active(converter_active));
`default_nettype wire

/* dv/adcsq_core_model.sv */
// Purpose: Behavioural converter core.
// Assumes: Answer latency set by the bench.
// Notes:   Data line toggles when not valid.
`default_nettype none
`include "adcsq_map.svh"
module adcsq_core_model
  import adcsq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_start,
  input wire adcsq_ch_t conv_channel,
  input wire logic [3:0] lat,
  output logic conv_done,
  output logic [`ADCSQ_RES_W-1:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  adcsq_ch_t ch_q[$];
  adcsq_ch_t ch;
  logic [`ADCSQ_RES_W-1:0] last [8];
  logic [`ADCSQ_RES_W-1:0] d;
  logic [3:0] cnt;
  logic busy;
  initial begin
    conv_done = 1'b0;
    conv_data = '0;
    busy = 1'b0;
    foreach (last[i]) last[i] = '0;
  end
  always @(posedge pclk) begin
    conv_done <= 1'b0;
    // Stale data must not look valid
    conv_data <= ~conv_data;
    if (!presetn) begin
      busy <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
      cnt <= lat;
      ch <= conv_channel;
      ch_q.push_back(conv_channel);
    end else if (busy && cnt == 4'h0) begin
      d = `ADCSQ_RES_W'($urandom());
      busy <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= d;
      last[ch] <= d;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : adcsq_core_model
`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench for the sequencing block.
// Assumes: Delays of one unit keep the run short.
// Notes:   Expected channels and readings come from the core log.
`default_nettype none
`include "adcsq_map.svh"
module tb
  import adcsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic conv_done, conv_start, converter_active;
  logic [7:0] paddr, m;
  logic [31:0] pwdata, prdata, rd, d;
  logic [9:0] conv_data;
  logic [3:0] lat;
  adcsq_ch_t conv_channel;
  int error_cnt = 0, checks = 0, cyc = 0, t0, n;
  adcsq_top u_dut(.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
    .conv_channel(conv_channel), .converter_active(converter_active));
  adcsq_core_model u_core(.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .conv_channel(conv_channel), .lat(lat),
    .conv_done(conv_done), .conv_data(conv_data));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    // Whole run needs about 20000 cycles
    if (cyc == 50000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll(input int b);
    n = 0;
    do begin
      apb(1'b0, `ADCSQ_OFF_CTRL, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 3000);
    chk(rd[b], 1'b1);
  endtask : poll
  task automatic pass_chk(input logic [7:0] k);
    n = 0;
    for (int c = 0; c < 8; c++) begin
      if (k[c]) begin
        chk(u_core.ch_q[n], c);
        n++;
      end
      apb(1'b0, 8'(`ADCSQ_OFF_RES_FIRST + 4 * c), 32'h0);
      chk(rd, {22'h0, u_core.last[c]});
    end
    chk(u_core.ch_q.size(), n);
    u_core.ch_q.delete();
  endtask : pass_chk
  // Every mapped word reads zero, only the hole answers with an error
  task automatic reg_zero();
    for (int a = 0; a <= 'h34; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
      chk(e, a == 'h14);
    end
  endtask : reg_zero
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lat = 4'h0;
    void'($urandom(32'h8f745fdd));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    reg_zero();
    $display("reset test done");
    d = $urandom();
    apb(1'b1, `ADCSQ_OFF_DELAY, d);
    apb(1'b0, `ADCSQ_OFF_DELAY, 32'h0);
    chk(rd, d);
    apb(1'b1, `ADCSQ_OFF_RES_FIRST, d);
    apb(1'b0, `ADCSQ_OFF_RES_FIRST, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
    m = 8'($urandom_range(254, 1));
    apb(1'b1, `ADCSQ_OFF_SINGLE, {24'h0, m});
    apb(1'b1, `ADCSQ_OFF_REPEAT, {24'h0, ~m});
    apb(1'b1, `ADCSQ_OFF_DELAY, 32'hffff_ffff);
    lat <= 4'($urandom());
    t0 = cyc;
    apb(1'b1, `ADCSQ_OFF_CTRL, 32'h3);
    poll(7);
    chk(cyc - t0 < 1000, 1'b1);
    chk(rd[1], 1'b0);
    pass_chk(m);
    apb(1'b0, `ADCSQ_OFF_FLAGS, 32'h0);
    chk(rd, {24'h0, m});
    d = $urandom();
    apb(1'b1, `ADCSQ_OFF_FLAGS, d);
    apb(1'b0, `ADCSQ_OFF_FLAGS, 32'h0);
    chk(rd, {24'h0, m & ~d[7:0]});
    apb(1'b1, `ADCSQ_OFF_FLAGS, 32'hff);
    $display("single test done");
    apb(1'b1, `ADCSQ_OFF_DELAY, 32'h0001_0001);
    t0 = cyc;
    apb(1'b1, `ADCSQ_OFF_CTRL, 32'h5);
    poll(6);
    chk(cyc - t0 >= `ADCSQ_UNIT_CYCLES, 1'b1);
    chk(cyc - t0 < `ADCSQ_UNIT_CYCLES + 400, 1'b1);
    // Gap is timed from one pass end to the next
    t0 = cyc;
    pass_chk(~m);
    apb(1'b1, `ADCSQ_OFF_CTRL, 32'h45);
    poll(6);
    chk(cyc - t0 >= `ADCSQ_UNIT_CYCLES, 1'b1);
    chk(cyc - t0 < 2 * `ADCSQ_UNIT_CYCLES, 1'b1);
    pass_chk(~m);
    apb(1'b1, `ADCSQ_OFF_CTRL, 32'h41);
    repeat (9000) @(posedge pclk);
    chk(u_core.ch_q.size(), 0);
    $display("repeat test done");
    apb(1'b1, `ADCSQ_OFF_SINGLE, 32'hff);
    lat <= 4'hf;
    apb(1'b1, `ADCSQ_OFF_CTRL, 32'hc1);
    apb(1'b1, `ADCSQ_OFF_CTRL, 32'h3);
    apb(1'b1, `ADCSQ_OFF_CTRL, 32'h0);
    chk(converter_active, 1'b1);
    poll(7);
    pass_chk(8'hff);
    chk(converter_active, 1'b0);
    apb(1'b1, `ADCSQ_OFF_CTRL, 32'h2);
    repeat (300) @(posedge pclk);
    chk(u_core.ch_q.size(), 0);
    $display("deactivate test done");
    // Flags, delays and selects are non-zero here, so reset must clear them
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reg_zero();
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
